// File: dpll_ctrl_pkg.sv
// constants, field layout and encodings of the dpll reference and feedback register bank
package dpll_ctrl_pkg;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned BANK_DEPTH = 64;

  localparam logic [7:0] ADDR_INPUT_SEL        = 8'h08;
  localparam logic [7:0] ADDR_PRIORITY         = 8'h09;
  localparam logic [7:0] ADDR_EXCL_STATE       = 8'h0A;
  localparam logic [7:0] ADDR_REF0_PRESCALE_HI = 8'h0B;
  localparam logic [7:0] ADDR_REF0_PRESCALE_MD = 8'h0C;
  localparam logic [7:0] ADDR_REF0_PRESCALE_LO = 8'h0D;
  localparam logic [7:0] ADDR_REF1_PRESCALE_HI = 8'h0E;
  localparam logic [7:0] ADDR_REF1_PRESCALE_MD = 8'h0F;
  localparam logic [7:0] ADDR_REF1_PRESCALE_LO = 8'h10;
  localparam logic [7:0] ADDR_REF0_FB_HI       = 8'h17;
  localparam logic [7:0] ADDR_REF0_FB_MD       = 8'h18;
  localparam logic [7:0] ADDR_REF0_FB_LO       = 8'h19;
  localparam logic [7:0] ADDR_REF1_FB_HI       = 8'h1A;
  localparam logic [7:0] ADDR_REF1_FB_MD       = 8'h1B;
  localparam logic [7:0] ADDR_REF1_FB_LO       = 8'h1C;
  localparam logic [7:0] ADDR_BANDWIDTH        = 8'h23;
  localparam logic [7:0] ADDR_DAMP_GAIN        = 8'h24;
  localparam logic [7:0] ADDR_TIGHT_CTRL       = 8'h25;
  localparam logic [7:0] ADDR_TIGHT_THR        = 8'h28;
  localparam logic [7:0] ADDR_FILL_FIRST       = 8'h2B;
  localparam logic [7:0] ADDR_FILL_LAST        = 8'h2E;
  localparam logic [7:0] ADDR_SLOPE_HOLD       = 8'h2F;
  localparam logic [7:0] ADDR_SETTLE           = 8'h30;
  localparam logic [7:0] ADDR_MOD_INT_HI       = 8'h31;
  localparam logic [7:0] ADDR_MOD_INT_LO       = 8'h32;
  localparam logic [7:0] ADDR_MOD_FRAC_HI      = 8'h33;
  localparam logic [7:0] ADDR_MOD_FRAC_MD      = 8'h34;
  localparam logic [7:0] ADDR_MOD_FRAC_LO      = 8'h35;
  localparam logic [7:0] ADDR_MOD_ORDER        = 8'h3A;

  localparam int unsigned REFERENCE_CHOICE_LSB  = 5;
  localparam int unsigned REVERT_BIT  = 1;
  localparam int unsigned PRI1_LSB    = 2;
  localparam int unsigned PRI0_LSB    = 0;
  localparam int unsigned EXCL1_BIT   = 5;
  localparam int unsigned EXCL0_BIT   = 4;
  localparam int unsigned FORCE_LSB   = 0;
  localparam int unsigned TRACK_BW_LSB = 4;
  localparam int unsigned ACQ_BW_LSB  = 0;
  localparam int unsigned GAIN_LSB    = 0;

  localparam logic [7:0] MASK_FULL       = 8'hFF;
  localparam logic [7:0] MASK_PRIORITY   = 8'h0F;
  localparam logic [7:0] MASK_EXCL_STATE = 8'h33;
  localparam logic [7:0] MASK_LOW5       = 8'h1F;
  localparam logic [7:0] MASK_TIGHT      = 8'hFE;
  localparam logic [7:0] MASK_SLOPE_HOLD = 8'hDB;
  localparam logic [7:0] MASK_LOW1       = 8'h01;
  localparam logic [7:0] MASK_MOD_ORDER  = 8'hF7;
  localparam logic [7:0] MASK_NONE       = 8'h00;

  localparam logic [7:0] RST_INPUT_SEL  = 8'h03;
  localparam logic [7:0] RST_PRIORITY   = 8'h04;
  localparam logic [7:0] RST_FB_HI      = 8'h07;
  localparam logic [7:0] RST_BANDWIDTH  = 8'h77;
  localparam logic [7:0] RST_DAMP_GAIN  = 8'h6D;
  localparam logic [7:0] RST_TIGHT_CTRL = 8'h06;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] FILL_VALUE     = 8'hFF;

  localparam logic [1:0] FORCE_AUTO     = 2'b00;
  localparam logic [1:0] FORCE_FREERUN  = 2'b01;
  localparam logic [1:0] FORCE_NORMAL   = 2'b10;
  localparam logic [1:0] FORCE_HOLDOVER = 2'b11;

  localparam logic [2:0] REF_AUTO   = 3'b000;
  localparam logic [2:0] REF_PIN    = 3'b001;
  localparam logic [2:0] REF_FORCE0 = 3'b100;
  localparam logic [2:0] REF_FORCE1 = 3'b101;

  typedef enum logic [1:0] {
    PLL_FREERUN  = 2'b00,
    PLL_NORMAL   = 2'b01,
    PLL_HOLDOVER = 2'b10
  } pll_state_e;
endpackage

// File: dpll_reference_feedback_control.sv
// register bank and reference switchover state control of the dpll
module dpll_reference_feedback_control
  import dpll_ctrl_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  input  wire logic              ref0_valid_i,
  input  wire logic              ref1_valid_i,
  input  wire logic              manual_ref_i,
  output logic                   active_ref_o,
  output pll_state_e             pll_state_o,
  output logic      [20:0]       prescale_ratio_o,
  output logic      [23:0]       feedback_ratio_o,
  output logic      [3:0]        tracking_bandwidth_o,
  output logic      [3:0]        acquire_bandwidth_o,
  output logic      [1:0]        loop_filter_gain_o,
  output logic      [8:0]        modulator_integer_o,
  output logic      [20:0]       modulator_fraction_o
);

  // writable bits per address; reserved bits are never stored
  function automatic logic [7:0] wr_mask(input logic [7:0] a);
    case (a)
      ADDR_INPUT_SEL, ADDR_REF0_PRESCALE_MD, ADDR_REF0_PRESCALE_LO,
      ADDR_REF1_PRESCALE_MD, ADDR_REF1_PRESCALE_LO,
      ADDR_REF0_FB_HI, ADDR_REF0_FB_MD, ADDR_REF0_FB_LO,
      ADDR_REF1_FB_HI, ADDR_REF1_FB_MD, ADDR_REF1_FB_LO,
      ADDR_BANDWIDTH, ADDR_DAMP_GAIN, ADDR_SETTLE, ADDR_MOD_INT_LO,
      ADDR_MOD_FRAC_MD, ADDR_MOD_FRAC_LO:             wr_mask = MASK_FULL;
      ADDR_PRIORITY:                                   wr_mask = MASK_PRIORITY;
      ADDR_EXCL_STATE:                                 wr_mask = MASK_EXCL_STATE;
      ADDR_REF0_PRESCALE_HI, ADDR_REF1_PRESCALE_HI,
      ADDR_MOD_FRAC_HI:                                wr_mask = MASK_LOW5;
      ADDR_TIGHT_CTRL, ADDR_TIGHT_THR:                 wr_mask = MASK_TIGHT;
      ADDR_SLOPE_HOLD:                                 wr_mask = MASK_SLOPE_HOLD;
      ADDR_MOD_INT_HI:                                 wr_mask = MASK_LOW1;
      ADDR_MOD_ORDER:                                  wr_mask = MASK_MOD_ORDER;
      default:                                         wr_mask = MASK_NONE;
    endcase
  endfunction

  function automatic logic [7:0] rst_val(input logic [7:0] a);
    case (a)
      ADDR_INPUT_SEL:  rst_val = RST_INPUT_SEL;
      ADDR_PRIORITY:   rst_val = RST_PRIORITY;
      ADDR_REF0_FB_HI,
      ADDR_REF1_FB_HI: rst_val = RST_FB_HI;
      ADDR_BANDWIDTH:  rst_val = RST_BANDWIDTH;
      ADDR_DAMP_GAIN:  rst_val = RST_DAMP_GAIN;
      ADDR_TIGHT_CTRL: rst_val = RST_TIGHT_CTRL;
      default:         rst_val = RST_ZERO;
    endcase
  endfunction

  logic [7:0] cfg_reg  [BANK_DEPTH];
  logic [7:0] cfg_next [BANK_DEPTH];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       in_bank;
  logic [5:0] bank_idx;

  assign in_bank  = (reg_addr_i < 8'(BANK_DEPTH));
  assign bank_idx = reg_addr_i[5:0];

  always_comb begin
    for (int i = 0; i < BANK_DEPTH; i++) begin
      cfg_next[i] = cfg_reg[i];
    end
    // reserved bits dropped on write, so software zeros there cost nothing
    if (reg_wr_i && in_bank) begin
      cfg_next[bank_idx] = reg_wdata_i & wr_mask(reg_addr_i);
    end
    rdata_next = rdata_reg;
    if (reg_rd_i) begin
      if (reg_addr_i >= ADDR_FILL_FIRST && reg_addr_i <= ADDR_FILL_LAST) begin
        rdata_next = FILL_VALUE;
      end else if (in_bank) begin
        rdata_next = cfg_reg[bank_idx] & wr_mask(reg_addr_i);
      end else begin
        rdata_next = RST_ZERO;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < BANK_DEPTH; i++) begin
        cfg_reg[i] <= rst_val(8'(i));
      end
      rdata_reg <= RST_ZERO;
    end else begin
      for (int i = 0; i < BANK_DEPTH; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  logic [2:0]  reference_choice;
  logic        revertive;
  logic [1:0]  ref0_switch_priority;
  logic [1:0]  ref1_switch_priority;
  logic        ref0_switch_exclude;
  logic        ref1_switch_exclude;
  logic [1:0]  pll_state_force;
  logic [20:0] ref0_prescale_ratio;
  logic [20:0] ref1_prescale_ratio;
  logic [23:0] ref0_feedback_ratio;
  logic [23:0] ref1_feedback_ratio;

  assign reference_choice     = cfg_reg[6'(ADDR_INPUT_SEL)][REFERENCE_CHOICE_LSB +: 3];
  assign revertive            = cfg_reg[6'(ADDR_INPUT_SEL)][REVERT_BIT];
  assign ref0_switch_priority = cfg_reg[6'(ADDR_PRIORITY)][PRI0_LSB +: 2];
  assign ref1_switch_priority = cfg_reg[6'(ADDR_PRIORITY)][PRI1_LSB +: 2];
  assign ref0_switch_exclude  = cfg_reg[6'(ADDR_EXCL_STATE)][EXCL0_BIT];
  assign ref1_switch_exclude  = cfg_reg[6'(ADDR_EXCL_STATE)][EXCL1_BIT];
  assign pll_state_force      = cfg_reg[6'(ADDR_EXCL_STATE)][FORCE_LSB +: 2];
  assign ref0_prescale_ratio  = {cfg_reg[6'(ADDR_REF0_PRESCALE_HI)][4:0],
                                 cfg_reg[6'(ADDR_REF0_PRESCALE_MD)],
                                 cfg_reg[6'(ADDR_REF0_PRESCALE_LO)]};
  assign ref1_prescale_ratio  = {cfg_reg[6'(ADDR_REF1_PRESCALE_HI)][4:0],
                                 cfg_reg[6'(ADDR_REF1_PRESCALE_MD)],
                                 cfg_reg[6'(ADDR_REF1_PRESCALE_LO)]};
  // most significant byte sits at the lowest address
  assign ref0_feedback_ratio  = {cfg_reg[6'(ADDR_REF0_FB_HI)],
                                 cfg_reg[6'(ADDR_REF0_FB_MD)],
                                 cfg_reg[6'(ADDR_REF0_FB_LO)]};
  assign ref1_feedback_ratio  = {cfg_reg[6'(ADDR_REF1_FB_HI)],
                                 cfg_reg[6'(ADDR_REF1_FB_MD)],
                                 cfg_reg[6'(ADDR_REF1_FB_LO)]};

  pll_state_e  state_reg;
  pll_state_e  state_next;
  logic        active_reg;
  logic        active_next;
  logic [20:0] prescale_reg;
  logic [20:0] prescale_next;
  logic [23:0] feedback_reg;
  logic [23:0] feedback_next;
  logic        elig0;
  logic        elig1;
  logic        have_ref;
  logic        choice;

  always_comb begin
    elig0 = ref0_valid_i & ~ref0_switch_exclude;
    elig1 = ref1_valid_i & ~ref1_switch_exclude;
    have_ref = 1'b0;
    choice   = active_reg;
    case (reference_choice)
      REF_PIN: begin
        choice   = manual_ref_i;
        have_ref = manual_ref_i ? ref1_valid_i : ref0_valid_i;
      end
      REF_FORCE0: begin
        choice   = 1'b0;
        have_ref = ref0_valid_i;
      end
      REF_FORCE1: begin
        choice   = 1'b1;
        have_ref = ref1_valid_i;
      end
      default: begin
        // reserved codes fall back to automatic selection
        have_ref = elig0 | elig1;
        if (elig0 && elig1) begin
          // non-revertive keeps a still usable locked reference
          if (!(revertive == 1'b0 && state_reg == PLL_NORMAL)) begin
            choice = (ref1_switch_priority < ref0_switch_priority);
          end
        end else begin
          choice = elig1;
        end
      end
    endcase
    active_next = have_ref ? choice : active_reg;
    unique case (pll_state_force)
      FORCE_FREERUN:  state_next = PLL_FREERUN;
      FORCE_NORMAL:   state_next = PLL_NORMAL;
      FORCE_HOLDOVER: state_next = PLL_HOLDOVER;
      FORCE_AUTO: begin
        // free-run only until a first reference has been seen
        if (have_ref) begin
          state_next = PLL_NORMAL;
        end else if (state_reg == PLL_FREERUN) begin
          state_next = PLL_FREERUN;
        end else begin
          state_next = PLL_HOLDOVER;
        end
      end
    endcase
    prescale_next = active_reg ? ref1_prescale_ratio : ref0_prescale_ratio;
    feedback_next = active_reg ? ref1_feedback_ratio : ref0_feedback_ratio;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg    <= PLL_FREERUN;
      active_reg   <= 1'b0;
      prescale_reg <= '0;
      feedback_reg <= '0;
    end else begin
      state_reg    <= state_next;
      active_reg   <= active_next;
      prescale_reg <= prescale_next;
      feedback_reg <= feedback_next;
    end
  end

  assign active_ref_o         = active_reg;
  assign pll_state_o          = state_reg;
  assign prescale_ratio_o     = prescale_reg;
  assign feedback_ratio_o     = feedback_reg;
  assign tracking_bandwidth_o = cfg_reg[6'(ADDR_BANDWIDTH)][TRACK_BW_LSB +: 4];
  assign acquire_bandwidth_o  = cfg_reg[6'(ADDR_BANDWIDTH)][ACQ_BW_LSB +: 4];
  assign loop_filter_gain_o   = cfg_reg[6'(ADDR_DAMP_GAIN)][GAIN_LSB +: 2];
  assign modulator_integer_o  = {cfg_reg[6'(ADDR_MOD_INT_HI)][0],
                                 cfg_reg[6'(ADDR_MOD_INT_LO)]};
  assign modulator_fraction_o = {cfg_reg[6'(ADDR_MOD_FRAC_HI)][4:0],
                                 cfg_reg[6'(ADDR_MOD_FRAC_MD)],
                                 cfg_reg[6'(ADDR_MOD_FRAC_LO)]};

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  logic auto_run;
  assign auto_run = (pll_state_force == FORCE_AUTO) && (reference_choice == REF_AUTO);

  sequence wr_fb_hi_s;
    reg_wr_i && reg_addr_i == ADDR_REF0_FB_HI;
  endsequence
  sequence both_ready_s;
    auto_run && revertive && ref0_valid_i && ref1_valid_i
      && !ref0_switch_exclude && !ref1_switch_exclude;
  endsequence

  force_freerun_a: assert property (
    pll_state_force == FORCE_FREERUN |=> pll_state_o == PLL_FREERUN)
    else $error("forced free-run not entered");
  force_holdover_a: assert property (
    pll_state_force == FORCE_HOLDOVER [*2] |=> pll_state_o == PLL_HOLDOVER [*1])
    else $error("forced holdover not held");
  exclude_ref0_a: assert property (
    auto_run && ref0_switch_exclude && elig1 |=> active_ref_o)
    else $error("excluded reference still selected");
  priority_pick_a: assert property (
    both_ready_s ##0 (ref1_switch_priority < ref0_switch_priority) |=> active_ref_o)
    else $error("higher priority reference 1 not chosen");
  priority_tie_a: assert property (
    both_ready_s ##0 (ref1_switch_priority >= ref0_switch_priority) |=> !active_ref_o)
    else $error("reference 0 not chosen on priority");
  prescale_follow_a: assert property (
    active_ref_o |=> prescale_ratio_o == $past(ref1_prescale_ratio))
    else $error("prescale ratio does not follow active reference");
  fb_byte_order_a: assert property (
    wr_fb_hi_s |=> ref0_feedback_ratio[23:16] == $past(reg_wdata_i))
    else $error("feedback high byte misplaced");
  no_ref_hold_a: assert property (
    auto_run && pll_state_o == PLL_NORMAL && !elig0 && !elig1
      |=> pll_state_o == PLL_HOLDOVER)
    else $error("holdover not entered without a reference");
  forced_ref1_a: assert property (
    pll_state_force == FORCE_AUTO && reference_choice == REF_FORCE1 && ref1_valid_i
      |=> active_ref_o && pll_state_o == PLL_NORMAL)
    else $error("forced reference 1 not taken");
  reserved_read_a: assert property (
    reg_rd_i && reg_addr_i == ADDR_MOD_ORDER |=> reg_rdata_o[3] == 1'b0)
    else $error("reserved bit reads nonzero");
  feedback_apply_a: assert property (
    active_ref_o [*2] |-> feedback_ratio_o == $past(ref1_feedback_ratio))
    else $error("feedback ratio not applied for reference 1");
  prescale_ref0_a: assert property (
    !active_ref_o |=> prescale_ratio_o == $past(ref0_prescale_ratio))
    else $error("prescale ratio of reference 0 not applied");
  feedback_ref0_a: assert property (
    !active_ref_o |=> feedback_ratio_o == $past(ref0_feedback_ratio))
    else $error("feedback ratio of reference 0 not applied");
  pin_choice_a: assert property (
    pll_state_force == FORCE_AUTO && reference_choice == REF_PIN && manual_ref_i
      && ref1_valid_i |=> active_ref_o && pll_state_o == PLL_NORMAL)
    else $error("pin choice of reference 1 not taken");
  force_normal_a: assert property (
    pll_state_force == FORCE_NORMAL |=> pll_state_o == PLL_NORMAL)
    else $error("forced normal state not entered");
endmodule

// File: tb.sv
// self-checking bench for the dpll reference and feedback register bank
module tb
  import dpll_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk;
  logic              rst_b;
  logic [7:0]        addr;
  logic              wr;
  logic [7:0]        wdata;
  logic              rd;
  logic [7:0]        rdata;
  logic              ref0_valid;
  logic              ref1_valid;
  logic              manual_ref;
  logic              active_ref;
  pll_state_e        pll_state;
  logic [20:0]       prescale;
  logic [23:0]       feedback;
  logic [3:0]        track_bw;
  logic [3:0]        acq_bw;
  logic [1:0]        gain;
  logic [8:0]        mod_int;
  logic [20:0]       mod_frac;
  int                fail_count;
  int                n_tests;

  // reset table: address and the value it must read after reset
  localparam logic [7:0] RST_ADDR [16] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E,
    8'h10, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1C, 8'h2B, 8'h2E, 8'h40};
  localparam logic [7:0] RST_EXP [16] = '{8'h03, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h07, 8'h00, 8'h00, 8'h07, 8'h00, 8'hFF, 8'hFF, 8'h00};
  // state force code and resulting state with no usable reference from holdover
  localparam logic [1:0] FRC_CODE [4] = '{2'b01, 2'b10, 2'b11, 2'b00};
  localparam pll_state_e FRC_EXP [4] = '{PLL_FREERUN, PLL_NORMAL, PLL_HOLDOVER, PLL_HOLDOVER};
  // choice register value, pin level, expected active reference
  localparam logic [7:0] SEL_VAL [4] = '{8'h22, 8'h22, 8'hA2, 8'h82};
  localparam logic       SEL_PIN [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  localparam logic       SEL_EXP [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  dpll_reference_feedback_control DUT (
    .core_clk_i           (clk),
    .rst_b_i              (rst_b),
    .reg_addr_i           (addr),
    .reg_wr_i             (wr),
    .reg_wdata_i          (wdata),
    .reg_rd_i             (rd),
    .reg_rdata_o          (rdata),
    .ref0_valid_i         (ref0_valid),
    .ref1_valid_i         (ref1_valid),
    .manual_ref_i         (manual_ref),
    .active_ref_o         (active_ref),
    .pll_state_o          (pll_state),
    .prescale_ratio_o     (prescale),
    .feedback_ratio_o     (feedback),
    .tracking_bandwidth_o (track_bw),
    .acquire_bandwidth_o  (acq_bw),
    .loop_filter_gain_o   (gain),
    .modulator_integer_o  (mod_int),
    .modulator_fraction_o (mod_frac)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic summarize();
    $display("counts: %0d checks, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_out(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one idle cycle between strobes keeps each pulse a single cycle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // read data holds until the next strobe, so a late sample is safe
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    chk_reg(nm, e, rdata);
  endtask

  // active reference then ratio outputs lag the cause by one register each
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  initial begin
    #2_000_000;
    fail_count++;
    $display("BAD watchdog expected finish seen hang");
    summarize();
  end

  initial begin
    fail_count = 0;
    n_tests = 0;
    rst_b = 1'b0;
    addr = 8'h00;
    wr = 1'b0;
    wdata = 8'h00;
    rd = 1'b0;
    ref0_valid = 1'b0;
    ref1_valid = 1'b0;
    manual_ref = 1'b0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    settle();
    chk_out("fb_reset", 24'h07_0000, feedback);
    chk_out("pre_reset", 24'h00_0000, {3'b000, prescale});
    chk_out("state_reset", {22'h00_0000, PLL_FREERUN}, {22'h00_0000, pll_state});
    chk_out("bw_gain_reset", 24'h00_0177, {14'h0000, gain, track_bw, acq_bw});
    for (int i = 0; i < 16; i++) begin
      rd_chk("reset_read", RST_ADDR[i], RST_EXP[i]);
    end
    $display("test reset done");

    wr_reg(8'h17, 8'h12);
    wr_reg(8'h18, 8'h34);
    wr_reg(8'h19, 8'h56);
    wr_reg(8'h1A, 8'hAB);
    wr_reg(8'h1B, 8'hCD);
    wr_reg(8'h1C, 8'hEF);
    wr_reg(8'h0B, 8'h1F);
    wr_reg(8'h0C, 8'h22);
    wr_reg(8'h0D, 8'h33);
    wr_reg(8'h0E, 8'h0A);
    wr_reg(8'h0F, 8'h0B);
    wr_reg(8'h10, 8'h0C);
    rd_chk("fb0_hi", 8'h17, 8'h12);
    rd_chk("fb1_lo", 8'h1C, 8'hEF);
    rd_chk("pre0_hi", 8'h0B, 8'h1F);
    $display("test ratios done");

    ref0_valid = 1'b1;
    ref1_valid = 1'b1;
    settle();
    chk_out("auto_ref0", 24'h00_0000, {23'h00_0000, active_ref});
    chk_out("auto_normal", {22'h00_0000, PLL_NORMAL}, {22'h00_0000, pll_state});
    chk_out("fb_ref0", 24'h12_3456, feedback);
    chk_out("pre_ref0", 24'h1F_2233, {3'b000, prescale});
    wr_reg(8'h09, 8'h01);
    settle();
    chk_out("prio_ref1", 24'h00_0001, {23'h00_0000, active_ref});
    chk_out("fb_ref1", 24'hAB_CDEF, feedback);
    chk_out("pre_ref1", 24'h0A_0B0C, {3'b000, prescale});
    wr_reg(8'h0A, 8'h20);
    settle();
    chk_out("excl_ref1", 24'h00_0000, {23'h00_0000, active_ref});
    ref0_valid = 1'b0;
    settle();
    chk_out("none_hold", {22'h00_0000, PLL_HOLDOVER}, {22'h00_0000, pll_state});
    chk_out("none_keep", 24'h00_0000, {23'h00_0000, active_ref});
    $display("test switchover done");

    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h0A, {6'b001000, FRC_CODE[i]});
      settle();
      chk_out("force", {22'h00_0000, FRC_EXP[i]}, {22'h00_0000, pll_state});
    end
    $display("test force done");

    ref0_valid = 1'b1;
    wr_reg(8'h0A, 8'h30);
    for (int i = 0; i < 4; i++) begin
      manual_ref = SEL_PIN[i];
      wr_reg(8'h08, SEL_VAL[i]);
      settle();
      chk_out("choice", {23'h00_0000, SEL_EXP[i]}, {23'h00_0000, active_ref});
      chk_out("choice_st", {22'h00_0000, PLL_NORMAL}, {22'h00_0000, pll_state});
    end
    $display("test choice done");

    wr_reg(8'h0A, 8'h10);
    wr_reg(8'h08, 8'h03);
    settle();
    chk_out("excl_ref0", 24'h00_0001, {23'h00_0000, active_ref});
    wr_reg(8'h09, 8'h04);
    // non-revertive keeps the locked reference over a better one
    wr_reg(8'h08, 8'h01);
    wr_reg(8'h0A, 8'h00);
    settle();
    chk_out("nonrevert_keep", 24'h00_0001, {23'h00_0000, active_ref});
    wr_reg(8'h08, 8'h03);
    settle();
    chk_out("revert_ref0", 24'h00_0000, {23'h00_0000, active_ref});
    chk_out("fb_back0", 24'h12_3456, feedback);
    $display("test revert done");

    wr_reg(8'h23, 8'h5A);
    wr_reg(8'h24, 8'h6E);
    wr_reg(8'h31, 8'h01);
    wr_reg(8'h32, 8'h23);
    wr_reg(8'h33, 8'h15);
    wr_reg(8'h34, 8'h67);
    wr_reg(8'h35, 8'h89);
    wr_reg(8'h3A, 8'hF7);
    settle();
    chk_out("bw_gain", 24'h00_025A, {14'h0000, gain, track_bw, acq_bw});
    chk_out("mod_int", 24'h00_0123, {15'h0000, mod_int});
    chk_out("mod_frac", 24'h15_6789, {3'b000, mod_frac});
    rd_chk("mod_order", 8'h3A, 8'hF7);
    $display("test config done");
    summarize();
  end
endmodule
